// [msg_center_ctrl.sv]
// Control registers and handshake state for message centers 2 through 12.
// Assumes the protocol engine supplies the per-center mode bit and event
// pulses, and accepts the tx_ready and store_ok levels per center.
`timescale 1ns/100ps

module msg_center_ctrl #(
  parameter int N = msg_ctrl_pkg::NUM_CENTERS
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       clk_en_in,
  input  wire msg_ctrl_pkg::sfr_req_t     sfr_req_in,
  input  wire logic                       overwrite_enable_in,
  input  wire logic [N-1:0]               tx_mode_in,
  input  wire msg_ctrl_pkg::engine_evt_t  evt_in [N],
  output logic [7:0]                      sfr_rdata_out,
  output logic                            sfr_hit_out,
  output logic [N-1:0]                    tx_ready_out,
  output logic [N-1:0]                    store_ok_out,
  output logic [N-1:0]                    irq_flag_out
);

  // ===========================================================================
  // Address decode: one function serves write, read and hit logic.
  function automatic int center_index(input logic [7:0] a);
    case (a)
      msg_ctrl_pkg::OFF_MC2:  center_index = 0;
      msg_ctrl_pkg::OFF_MC3:  center_index = 1;
      msg_ctrl_pkg::OFF_MC4:  center_index = 2;
      msg_ctrl_pkg::OFF_MC5:  center_index = 3;
      msg_ctrl_pkg::OFF_MC6:  center_index = 4;
      msg_ctrl_pkg::OFF_MC7:  center_index = 5;
      msg_ctrl_pkg::OFF_MC8:  center_index = 6;
      msg_ctrl_pkg::OFF_MC9:  center_index = 7;
      msg_ctrl_pkg::OFF_MC10: center_index = 8;
      msg_ctrl_pkg::OFF_MC11: center_index = 9;
      msg_ctrl_pkg::OFF_MC12: center_index = 10;
      default:                center_index = -1;
    endcase
  endfunction

  logic [7:0]   ctrl_reg      [N];
  logic [7:0]   ctrl_next     [N];
  logic [7:0]   rdata_reg;
  logic [7:0]   rdata_next;
  logic         hit_reg;
  logic         hit_next;
  logic [N-1:0] tx_ready_reg;
  logic [N-1:0] tx_ready_next;
  logic [N-1:0] store_ok_reg;
  logic [N-1:0] store_ok_next;
  int           sel;

  assign sel = center_index(sfr_req_in.addr);

  // ===========================================================================
  // Next state of every center. Hardware sets are applied after the software
  // write so that an event in the same cycle as a clear is never lost.
  always_comb begin
    for (int i = 0; i < N; i++) begin // R15
      logic [7:0] c;
      logic       wr_me;
      logic       store;
      c     = ctrl_reg[i];
      wr_me = sfr_req_in.wr && (sel == i);
      store = 1'b0;
      if (wr_me) begin
        // Upper four bits plain read/write.
        c[7:4] = sfr_req_in.wdata[7:4]; // R11
        // Software may only clear the remote request flag, never set it.
        c[msg_ctrl_pkg::BIT_EXT_REQ] = ctrl_reg[i][msg_ctrl_pkg::BIT_EXT_REQ] &
                                       sfr_req_in.wdata[msg_ctrl_pkg::BIT_EXT_REQ]; // R11
        c[msg_ctrl_pkg::BIT_PROC_TXREQ] = sfr_req_in.wdata[msg_ctrl_pkg::BIT_PROC_TXREQ];
        c[msg_ctrl_pkg::BIT_DATA_UPD]   = sfr_req_in.wdata[msg_ctrl_pkg::BIT_DATA_UPD];
        if (tx_mode_in[i]) begin
          c[msg_ctrl_pkg::BIT_OVW_INH] = sfr_req_in.wdata[msg_ctrl_pkg::BIT_OVW_INH]; // R11
        end else if (!sfr_req_in.wdata[msg_ctrl_pkg::BIT_DATA_UPD]) begin
          // Overwrite flag is read only and falls when data_updated is cleared.
          c[msg_ctrl_pkg::BIT_OVW_INH] = 1'b0;
        end
      end
      // Receive side: storage blocked when overwrite off and data still unread.
      if (!tx_mode_in[i] && evt_in[i].rx_stored) begin
        if (overwrite_enable_in || !ctrl_reg[i][msg_ctrl_pkg::BIT_DATA_UPD]) begin // R13
          store = 1'b1;
        end
      end
      if (store) begin
        if (ctrl_reg[i][msg_ctrl_pkg::BIT_DATA_UPD]) begin
          c[msg_ctrl_pkg::BIT_OVW_INH] = 1'b1;
        end
        c[msg_ctrl_pkg::BIT_DATA_UPD] = 1'b1; // R12
        if (ctrl_reg[i][msg_ctrl_pkg::BIT_RX_IRQ_EN]) begin
          c[msg_ctrl_pkg::BIT_IRQ_FLAG] = 1'b1; // R14
        end
      end
      // Completion: request cleared, data_updated left alone.
      if (evt_in[i].tx_done) begin
        c[msg_ctrl_pkg::BIT_PROC_TXREQ] = 1'b0; // R9 R8
        if (tx_mode_in[i]) begin
          c[msg_ctrl_pkg::BIT_EXT_REQ] = 1'b0;
        end
        if (ctrl_reg[i][msg_ctrl_pkg::BIT_TX_IRQ_EN]) begin
          c[msg_ctrl_pkg::BIT_IRQ_FLAG] = 1'b1;
        end
      end
      // A remote request with no completion in the same cycle also raises the processor request in transmit mode.
      if (evt_in[i].remote_rx && !evt_in[i].tx_done) begin
        c[msg_ctrl_pkg::BIT_EXT_REQ] = 1'b1;
        if (tx_mode_in[i]) begin
          c[msg_ctrl_pkg::BIT_PROC_TXREQ] = 1'b1;
        end
      end
      ctrl_next[i] = c;
    end
  end

  // ===========================================================================
  // Engine-facing levels, computed from the next state so they track the
  // registers without an extra cycle of lag.
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (tx_mode_in[i]) begin
        tx_ready_next[i] = ctrl_next[i][msg_ctrl_pkg::BIT_MSG_READY] &
                           ctrl_next[i][msg_ctrl_pkg::BIT_PROC_TXREQ] &
                           ctrl_next[i][msg_ctrl_pkg::BIT_DATA_UPD] &
                           !ctrl_next[i][msg_ctrl_pkg::BIT_OVW_INH]; // R6
      end else begin
        // Remote request gated only by ready and request; data_updated ignored.
        tx_ready_next[i] = ctrl_next[i][msg_ctrl_pkg::BIT_MSG_READY] &
                           ctrl_next[i][msg_ctrl_pkg::BIT_PROC_TXREQ]; // R4 R3
      end
      store_ok_next[i] = !tx_mode_in[i] &&
                         (overwrite_enable_in ||
                          !ctrl_next[i][msg_ctrl_pkg::BIT_DATA_UPD]); // R13
    end
  end

  // Read data and hit flag, registered so outputs come from flip-flops.
  always_comb begin
    rdata_next = 8'h00;
    hit_next   = 1'b0;
    if (sfr_req_in.rd && sel >= 0) begin
      rdata_next = ctrl_reg[sel];
      hit_next   = 1'b1;
    end
  end

  // ===========================================================================
  // Registers, frozen while the clock enable is low.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < N; i++) begin
        ctrl_reg[i] <= msg_ctrl_pkg::CTRL_RESET; // R10
      end
      rdata_reg    <= 8'h00;
      hit_reg      <= 1'b0;
      tx_ready_reg <= '0;
      store_ok_reg <= '0;
    end else if (clk_en_in) begin
      ctrl_reg     <= ctrl_next;
      rdata_reg    <= rdata_next;
      hit_reg      <= hit_next;
      tx_ready_reg <= tx_ready_next;
      store_ok_reg <= store_ok_next;
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      irq_flag_out[i] = ctrl_reg[i][msg_ctrl_pkg::BIT_IRQ_FLAG];
    end
  end

  assign sfr_rdata_out = rdata_reg;
  assign sfr_hit_out   = hit_reg;
  assign tx_ready_out  = tx_ready_reg;
  assign store_ok_out  = store_ok_reg;

  // ===========================================================================
  // Checks on center 0 (message center 2) as a representative.
  sequence s_done_seen;
    clk_en_in && evt_in[0].tx_done && !evt_in[0].remote_rx;
  endsequence

  chk_txreq_cleared: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R9
    s_done_seen |=> !ctrl_reg[0][msg_ctrl_pkg::BIT_PROC_TXREQ])
    else $error("Transmit request not cleared after completion.");

  chk_dup_kept_tx: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R8
    s_done_seen and (!(sfr_req_in.wr && sel == 0) && tx_mode_in[0]) |=>
      ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD] == $past(ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD]))
    else $error("Data updated flag changed by completion.");

  chk_inhibit_blocks: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R6
    tx_mode_in[0] && ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH] && $stable(tx_mode_in[0])
      && $stable(ctrl_reg[0]) |-> !tx_ready_reg[0])
    else $error("Inhibited center offered for transmit.");

  chk_rx_gate_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R4
    clk_en_in && !tx_mode_in[0] |=> tx_ready_reg[0] ==
      (ctrl_reg[0][msg_ctrl_pkg::BIT_MSG_READY] & ctrl_reg[0][msg_ctrl_pkg::BIT_PROC_TXREQ]))
    else $error("Remote request gating wrong.");

  chk_store_sets_dup: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R12
    clk_en_in && !tx_mode_in[0] && evt_in[0].rx_stored && overwrite_enable_in
      |=> ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD])
    else $error("Stored message did not set data updated.");

  chk_no_overwrite: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R13
    clk_en_in && !tx_mode_in[0] && !overwrite_enable_in &&
      !ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH] && !(sfr_req_in.wr && sel == 0)
      |=> !ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH])
    else $error("Overwrite flagged with overwrite disabled.");

  chk_rx_irq_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R14
    clk_en_in && !tx_mode_in[0] && evt_in[0].rx_stored &&
      ctrl_reg[0][msg_ctrl_pkg::BIT_RX_IRQ_EN] && !ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD]
      |=> irq_flag_out[0])
    else $error("Receive interrupt flag not set.");

  chk_ext_clear_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R11
    !ctrl_reg[0][msg_ctrl_pkg::BIT_EXT_REQ] && !evt_in[0].remote_rx
      |=> !ctrl_reg[0][msg_ctrl_pkg::BIT_EXT_REQ])
    else $error("Remote request flag set by software.");

  chk_reset_zero: assert property (@(posedge sys_clk_in) // R10
    !rst_n_in |=> ctrl_reg[0] == msg_ctrl_pkg::CTRL_RESET && !tx_ready_reg[0])
    else $error("Control register not zero after reset.");

  // ===========================================================================
  // Further checks on center 0. Software writes and remote requests are named
  // once so that the properties below read as cause and effect.
  sequence s_sw_write0;
    clk_en_in && sfr_req_in.wr && sel == 0;
  endsequence

  sequence s_remote_seen;
    clk_en_in && evt_in[0].remote_rx && !evt_in[0].tx_done;
  endsequence

  // A transmit center is offered only with every handshake bit in place.
  chk_tx_gate_full: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R6
    clk_en_in && tx_mode_in[0] |=> tx_ready_reg[0] ==
      (ctrl_reg[0][msg_ctrl_pkg::BIT_MSG_READY] & ctrl_reg[0][msg_ctrl_pkg::BIT_PROC_TXREQ] &
       ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD] & !ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH]))
    else $error("Transmit gating wrong.");

  // Unread data in receive mode must not hold back a remote frame request.
  chk_rx_dup_no_block: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R3
    !tx_mode_in[0] && $stable(tx_mode_in[0]) && ctrl_reg[0][msg_ctrl_pkg::BIT_MSG_READY] &&
      ctrl_reg[0][msg_ctrl_pkg::BIT_PROC_TXREQ] && ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD]
      |-> tx_ready_reg[0])
    else $error("Data updated blocked a remote request.");

  // With overwrite off, a receive center holding unread data refuses storage.
  chk_store_refused: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R13
    !tx_mode_in[0] && !overwrite_enable_in && ctrl_reg[0][msg_ctrl_pkg::BIT_DATA_UPD] &&
      $stable(tx_mode_in[0]) && $stable(overwrite_enable_in) |-> !store_ok_out[0])
    else $error("Storage offered over unread data.");

  // Clearing data_updated in receive mode also drops the overwrite flag.
  chk_ovw_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R11
    s_sw_write0 ##0 (!tx_mode_in[0] && !sfr_req_in.wdata[msg_ctrl_pkg::BIT_DATA_UPD] &&
      !evt_in[0].rx_stored) |=> !ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH])
    else $error("Overwrite flag kept after data updated clear.");

  // The overwrite flag is read only in receive mode: a write never raises it.
  chk_ovw_read_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R11
    s_sw_write0 ##0 (!tx_mode_in[0] && !ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH] &&
      !evt_in[0].rx_stored) |=> !ctrl_reg[0][msg_ctrl_pkg::BIT_OVW_INH])
    else $error("Overwrite flag set by software.");

  // A remote request with no completion in the same cycle raises the external flag, and the request bit in transmit.
  chk_remote_sets: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R11
    s_remote_seen |=> ctrl_reg[0][msg_ctrl_pkg::BIT_EXT_REQ] &&
      (!$past(tx_mode_in[0]) || ctrl_reg[0][msg_ctrl_pkg::BIT_PROC_TXREQ]))
    else $error("Remote request not recorded.");

  // Only software clears the interrupt flag.
  chk_irq_held: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R14
    clk_en_in && irq_flag_out[0] && !(sfr_req_in.wr && sel == 0) |=> irq_flag_out[0])
    else $error("Interrupt flag cleared without software.");

  // A low clock enable freezes the center; a stall must never lose a bit.
  chk_freeze_state: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // R15
    !clk_en_in |=> $stable(ctrl_reg[0]) && $stable(tx_ready_reg[0]))
    else $error("State changed while clock enable low.");

endmodule

// [msg_ctrl_pkg.sv]
// Package for the per-message-center control and status logic.
// Assumes an SFR-style 8-bit register port from the host processor and a
// protocol engine that reports per-center events as one-cycle pulses.
// =============================================================================
// How it works
// R1: With overwrite on, software clears data_updated, reads the center, and rereads if the flag came back.
// R2: With overwrite off, software only needs to clear data_updated after it has read the center.
// R3: In receive mode, data_updated never blocks sending a remote frame request.
// R4: In receive mode a remote request goes out only when message_ready and processor_tx_request are both set.
// R5: In transmit mode, software sets transmit_inhibit and clears data_updated before changing a center.
// R6: While transmit_inhibit is set on a transmit center, its data is not offered for sending.
// R7: After an update, software clears transmit_inhibit and sets message_ready, processor_tx_request, data_updated.
// R8: A completed transmission leaves data_updated of a transmit center untouched.
// R9: A successful transmission clears processor_tx_request so software can poll for completion.
// R10: Each control register is 8 bits with the fixed field layout below, all bits reset to zero.
// R11: The upper four bits are read/write, external_remote_request is clear-only, bits 2..0 depend on mode.
// R12: In receive mode a successfully stored message sets data_updated.
// R13: With overwrite off, a receive center whose data_updated is set ignores incoming messages and never flags overwrite.
// R14: A stored message with rx_irq_enable set raises center_irq_flag, which only software clears.
// R15: Every message center has its own independent control state, selected by its register address.
package msg_ctrl_pkg;

  // ===========================================================================
  // Register field positions.
  localparam int BIT_MSG_READY  = 7;
  localparam int BIT_TX_IRQ_EN  = 6;
  localparam int BIT_RX_IRQ_EN  = 5;
  localparam int BIT_IRQ_FLAG   = 4;
  localparam int BIT_EXT_REQ    = 3;
  localparam int BIT_PROC_TXREQ = 2;
  localparam int BIT_OVW_INH    = 1;
  localparam int BIT_DATA_UPD   = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int         NUM_CENTERS = 11;

  // ===========================================================================
  // Register offsets, in center order 2..12; the center 7 offset is a free choice.
  localparam logic [7:0] OFF_MC2  = 8'hEC;
  localparam logic [7:0] OFF_MC3  = 8'hED;
  localparam logic [7:0] OFF_MC4  = 8'hEE;
  localparam logic [7:0] OFF_MC5  = 8'hEF;
  localparam logic [7:0] OFF_MC6  = 8'hF3;
  localparam logic [7:0] OFF_MC7  = 8'hF4;
  localparam logic [7:0] OFF_MC8  = 8'hF5;
  localparam logic [7:0] OFF_MC9  = 8'hF6;
  localparam logic [7:0] OFF_MC10 = 8'hF7;
  localparam logic [7:0] OFF_MC11 = 8'hFB;
  localparam logic [7:0] OFF_MC12 = 8'hFC;

  // Register access from the processor.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Per-center events from the protocol engine, one-cycle pulses.
  typedef struct packed {
    logic rx_stored;  // Message matched and was offered for storage.
    logic tx_done;    // Frame from this center sent successfully.
    logic remote_rx;  // Remote frame request seen for this center.
  } engine_evt_t;

endpackage

// [can_engine_model.sv]
// Behavioural protocol engine standing on the far side of the message centers.
// Assumes the bench requests receive and remote events by one-cycle strobes.
`timescale 1ns/100ps

module can_engine_model #(
  parameter int N = 11
) (
  input  wire logic                      clk_in,
  input  wire logic                      slow_in,
  input  wire logic [N-1:0]              tx_ready_in,
  input  wire logic [N-1:0]              rx_req_in,
  input  wire logic [N-1:0]              rm_req_in,
  output msg_ctrl_pkg::engine_evt_t      evt_out [N]
);
  int cnt [N];

  // ===========================================================================
  // Frame sending
  // A frame takes 4 or 21 cycles and only completes if the center stays
  // ready throughout, so a late inhibit really cancels it.
  always @(posedge clk_in) begin
    for (int i = 0; i < N; i++) begin
      evt_out[i] <= '{rx_req_in[i], 1'b0, rm_req_in[i]};
      cnt[i] <= tx_ready_in[i] ? cnt[i] + 1 : 0;
      if (tx_ready_in[i] && cnt[i] == (slow_in ? 20 : 3)) begin
        evt_out[i].tx_done <= 1'b1;
        cnt[i] <= -50;  // The gap covers the lag before ready falls.
      end
    end
  end
endmodule

// [can_msg_center_control_tb.sv]
// Self-checking bench for the message center control registers.
// Assumes the engine model above and the register port of the package.
`timescale 1ns/100ps

module can_msg_center_control_tb;
  localparam int N = msg_ctrl_pkg::NUM_CENTERS;
  localparam logic [7:0] OFFS [N] = '{8'hEC, 8'hED, 8'hEE, 8'hEF, 8'hF3, 8'hF4,
                                      8'hF5, 8'hF6, 8'hF7, 8'hFB, 8'hFC};
  logic                      sys_clk_in = 1'b0;
  logic                      rst_n_in = 1'b0;
  logic                      ovw = 1'b0;
  logic                      slow = 1'b0;
  logic                      clk_en = 1'b1;
  logic [N-1:0]              tx_mode = '0;
  logic [N-1:0]              rx_req = '0;
  logic [N-1:0]              rm_req = '0;
  msg_ctrl_pkg::sfr_req_t    req = '0;
  msg_ctrl_pkg::engine_evt_t evt [N];
  logic [7:0]                rdata;
  logic                      hit;
  logic [N-1:0]              tx_ready;
  logic [N-1:0]              store_ok;
  logic [N-1:0]              irq;
  logic                      rd_pend = 1'b0;
  logic [8:0]                expq [$];
  logic [7:0]                dv [N];
  int                        miscompares = 0;
  int                        check_count = 0;

  // ===========================================================================
  // Clock, design and far side
  always #2.5 sys_clk_in = ~sys_clk_in;

  msg_center_ctrl #(.N(N)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en), .sfr_req_in(req),
    .overwrite_enable_in(ovw), .tx_mode_in(tx_mode), .evt_in(evt), .sfr_rdata_out(rdata),
    .sfr_hit_out(hit), .tx_ready_out(tx_ready), .store_ok_out(store_ok), .irq_flag_out(irq));

  can_engine_model #(.N(N)) engine_u (
    .clk_in(sys_clk_in), .slow_in(slow), .tx_ready_in(tx_ready), .rx_req_in(rx_req),
    .rm_req_in(rm_req), .evt_out(evt));

  // ===========================================================================
  // Compare tasks and the closing report
  task automatic cmp_read(logic [8:0] exp, logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error read expected %h seen %h", exp, got);
    end
  endtask

  task automatic cmp_lvl(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ===========================================================================
  // Drivers: every operation is followed by an idle cycle, so no signal is
  // assigned twice in one time step.
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk_in);
    req = '{w, ~w, a, d};
    @(negedge sys_clk_in);
    req = '0;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e, logic h);
    expq.push_back({h, e});
    bus(1'b0, a, 8'h00);
  endtask

  task automatic pulse(logic is_rx, int i);
    @(negedge sys_clk_in);
    if (is_rx) rx_req[i] = 1'b1;
    else rm_req[i] = 1'b1;
    @(negedge sys_clk_in);
    rx_req = '0;
    rm_req = '0;
  endtask

  task automatic wait_low(int i);
    int k;
    for (k = 0; k < 200 && tx_ready[i] !== 1'b0; k++) @(negedge sys_clk_in);
    if (k == 200) begin
      miscompares++;
      $display("Error tx_ready expected 0 seen 1");
      report_and_stop();
    end
  endtask

  // Read data is looked at in the one cycle it stands, oldest note first.
  always @(posedge sys_clk_in) rd_pend <= req.rd;
  always @(negedge sys_clk_in) begin
    if (rd_pend && expq.size() > 0) cmp_read(expq.pop_front(), {hit, rdata});
  end

  // ===========================================================================
  // Main sequence
  initial begin
    void'($urandom(23012));
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    for (int i = 0; i < N; i++) rd(OFFS[i], 8'h00, 1'b1);
    rd(8'hF0, 8'h00, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < N; i++) begin
      dv[i] = {4'($urandom()), 4'b1000};
      wr(OFFS[i], dv[i]);
    end
    for (int i = 0; i < N; i++) begin
      rd(OFFS[i], {dv[i][7:4], 4'h0}, 1'b1);
      cmp_lvl("irq_flag", dv[i][4], irq[i]);
      wr(OFFS[i], 8'h00);
    end
    $display("test access kinds done");
    wr(8'hEC, 8'h20);
    pulse(1'b1, 0);
    rd(8'hEC, 8'h31, 1'b1);
    cmp_lvl("store_ok", 1'b0, store_ok[0]);
    pulse(1'b1, 0);
    rd(8'hEC, 8'h31, 1'b1);
    ovw = 1'b1;
    wr(8'hEC, 8'h20);
    pulse(1'b1, 0);
    pulse(1'b1, 0);
    rd(8'hEC, 8'h33, 1'b1);
    cmp_lvl("store_ok", 1'b1, store_ok[0]);
    wr(8'hEC, 8'h20);
    rd(8'hEC, 8'h20, 1'b1);
    $display("test receive storage done");
    slow = 1'b1;
    wr(8'hED, 8'h84);
    pulse(1'b1, 1);
    rd(8'hED, 8'h85, 1'b1);
    cmp_lvl("tx_ready", 1'b1, tx_ready[1]);
    wait_low(1);
    rd(8'hED, 8'h81, 1'b1);
    wr(8'hED, 8'h04);
    cmp_lvl("tx_ready", 1'b0, tx_ready[1]);
    wr(8'hED, 8'h00);
    $display("test remote request done");
    slow = 1'b0;
    tx_mode[2] = 1'b1;
    wr(8'hEE, 8'hC6);
    pulse(1'b0, 2);
    rd(8'hEE, 8'hCE, 1'b1);
    cmp_lvl("tx_ready", 1'b0, tx_ready[2]);
    wr(8'hEE, 8'hCD);
    wait_low(2);
    rd(8'hEE, 8'hD1, 1'b1);
    cmp_lvl("irq_flag", 1'b1, irq[2]);
    $display("test transmit update done");
    // A write while the clock enable is low must not land.
    clk_en = 1'b0;
    wr(8'hEF, 8'hF0);
    clk_en = 1'b1;
    rd(8'hEF, 8'h00, 1'b1);
    $display("test clock enable done");
    // A second reset in mid-run must bring a finished transmit center, flags still set, back to zero.
    @(negedge sys_clk_in);
    rst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    rd(8'hEE, 8'h00, 1'b1);
    cmp_lvl("tx_ready", 1'b0, tx_ready[2]);
    $display("test mid-run reset done");
    repeat (3) @(negedge sys_clk_in);
    report_and_stop();
  end
endmodule
